/* hdl/lesq_top.v */
// LED engine sequencer: bus slave, interrupts and three program engines.
`timescale 1ns/100ps
`include "lesq_defs.vh"
module lesq_top
#(
  parameter MS_CYCLES = `LESQ_MS_NS / `LESQ_CLK_NS
)
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_trig_i,
  output reg ext_trig_o,
  output wire [2:0] pwm_o,
  output wire irq_o
);
  // Engine states.
  localparam S_FETCH = 3'd0;
  localparam S_EXEC = 3'd1;
  localparam S_RAMP = 3'd2;
  localparam S_WAIT = 3'd3;
  localparam S_TRIG = 3'd4;
  localparam S_ENDED = 3'd5;

  // Bus registers and status.
  reg [7:0] ctrl_r; // Execution modes of the three engines.
  reg [2:0] stat_r; // Sticky end interrupts, one per engine.
  reg [2:0] mask_r; // Interrupt enables, same layout as status.
  reg [31:0] rdat_nxt; // Read data for the current address.
  wire req; // A bus cycle is pending.
  wire wr_go; // Write takes effect at this edge.
  wire [2:0] irq_set; // End-with-interrupt pulses from the engines.
  wire [23:0] duty_all; // Applied duty of each engine.
  wire [14:0] pc_all; // Program counter of each engine.
  wire [11:0] send_all; // Engine i to target j at bit 4i+j.
  wire [2:0] ext_send; // Engine asks to pulse the external line.

  // Millisecond timebase shared by all engines.
  reg [31:0] ms_cnt_r;
  reg ms_tick_r;

  // External trigger synchroniser and edge detect.
  reg ext_m_r;
  reg ext_s_r;
  reg ext_d_r;
  wire ext_rise;

  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples the acknowledge.
  assign wr_go = req & wb_we_i & wb_ack_o;
  assign ext_rise = ext_s_r & ~ext_d_r;
  // Level interrupt while any unmasked status bit is set.
  assign irq_o = |(stat_r & mask_r);

  // Bus acknowledge: one cycle after the strobe, dropped the cycle after.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rdat_nxt;
    end
  end

  // Read multiplexer; unmapped and program addresses read as zero.
  always @*
  begin
    rdat_nxt = 32'h00000000;
    case (wb_adr_i)
      `LESQ_ADR_CTRL: rdat_nxt = {24'h000000, ctrl_r};
      `LESQ_ADR_STAT: rdat_nxt = {29'h00000000, stat_r};
      `LESQ_ADR_MASK: rdat_nxt = {29'h00000000, mask_r};
      `LESQ_ADR_DUTY: rdat_nxt = {8'h00, duty_all};
      `LESQ_ADR_PC: rdat_nxt = {11'h000, pc_all[14:10], 3'h0, pc_all[9:5],
        3'h0, pc_all[4:0]};
      default: rdat_nxt = 32'h00000000;
    endcase
  end

  // Control, status and mask registers; a set beats a same-cycle clear.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `LESQ_CTRL_RST;
      stat_r <= 3'h0;
      mask_r <= 3'h0;
    end
    else
    begin
      if (wr_go && wb_sel_i[0] && wb_adr_i == `LESQ_ADR_CTRL)
      begin
        ctrl_r <= wb_dat_i[7:0];
      end
      if (wr_go && wb_sel_i[0] && wb_adr_i == `LESQ_ADR_MASK)
      begin
        mask_r <= wb_dat_i[2:0];
      end
      if (wr_go && wb_sel_i[0] && wb_adr_i == `LESQ_ADR_STAT)
      begin
        stat_r <= (stat_r & ~wb_dat_i[2:0]) | irq_set;
      end
      else
      begin
        stat_r <= stat_r | irq_set;
      end
    end
  end

  // Millisecond tick: one pulse every MS_CYCLES clocks.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ms_cnt_r <= 32'h00000000;
      ms_tick_r <= 1'b0;
    end
    else if (ms_cnt_r == MS_CYCLES - 1)
    begin
      ms_cnt_r <= 32'h00000000;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      ms_cnt_r <= ms_cnt_r + 32'h00000001;
      ms_tick_r <= 1'b0;
    end
  end

  // External line: two flops, then an edge detector on the second.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_m_r <= 1'b0;
      ext_s_r <= 1'b0;
      ext_d_r <= 1'b0;
      ext_trig_o <= 1'b0;
    end
    else
    begin
      ext_m_r <= ext_trig_i;
      ext_s_r <= ext_m_r;
      ext_d_r <= ext_s_r;
      ext_trig_o <= |ext_send;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1)
    begin : g_eng
      reg [2:0] st_r; // Engine state.
      reg [4:0] pc_r; // Program counter within the own section.
      reg [7:0] duty_r; // Applied duty.
      reg [7:0] steps_r; // Ramp steps still to take.
      reg neg_r; // Ramp lowers the duty.
      reg [9:0] tgt_r; // Milliseconds per step or per wait.
      reg [9:0] tmr_r; // Milliseconds elapsed in this interval.
      reg [5:0] loop_r; // Remaining branch repeats.
      reg loop_act_r; // A counted loop is in progress.
      reg [3:0] seen_r; // Triggers received: r, g, b, external.
      reg [3:0] wmask_r; // Sources the current trigger waits on.
      reg [3:0] send_r; // One-cycle trigger send pulses.
      reg irq_r; // One-cycle end interrupt pulse.
      wire [3:0] rx; // Incoming trigger pulses this cycle.
      wire [23:0] ins; // Instruction at the program counter.
      wire [1:0] mode; // Mode field from the control register.
      wire mem_we; // Bus write into this section.
      wire run; // Engine allowed to execute.
      wire tick_done; // Interval elapses on this tick.

      assign mode = ctrl_r[`LESQ_MODE_HI - 2 * i -: 2];
      assign run = (mode == `LESQ_MODE_RUN);
      assign rx = {ext_rise, send_all[8 + i], send_all[4 + i], send_all[i]};
      assign mem_we = wr_go && (&wb_sel_i[2:0]) &&
        (wb_adr_i[9:7] == `LESQ_ADR_MEM0 / 128 + i) &&
        (wb_adr_i < `LESQ_ADR_MEM3);
      assign tick_done = ms_tick_r && ({1'b0, tmr_r} + 11'h001 >= {1'b0, tgt_r});
      assign irq_set[i] = irq_r;
      assign ext_send[i] = send_r[3];
      assign send_all[4 * i + 3 -: 4] = send_r;
      assign duty_all[8 * i + 7 -: 8] = duty_r;
      assign pc_all[5 * i + 4 -: 5] = pc_r;

      // Each engine has a private section and reads only that one.
      lesq_pmem u_mem
      (
        .clk_i(clk_i),
        .we_i(mem_we),
        .waddr_i(wb_adr_i[6:2]),
        .wdata_i(wb_dat_i[23:0]),
        .raddr_i(pc_r),
        .rdata_o(ins)
      );

      // Channel PWM driven from the applied duty.
      lesq_pwm u_pwm
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .duty_i(duty_r),
        .pwm_o(pwm_o[i])
      );

      // Trigger capture: arrivals are sticky and win over the clear.
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          seen_r <= 4'h0;
        end
        else if (st_r == S_TRIG && run && (seen_r & wmask_r) == wmask_r)
        begin
          seen_r <= (seen_r & ~wmask_r) | rx;
        end
        else
        begin
          seen_r <= seen_r | rx;
        end
      end

      // Program engine. Fetch takes one cycle since memory reads are
      // registered; leaving run mode for a hold mode freezes a ramp, wait or trigger wait in place but sends an ended engine back to fetch, mode three rewinds it.
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          st_r <= S_FETCH;
          pc_r <= 5'h00;
          duty_r <= 8'h00;
          steps_r <= 8'h00;
          neg_r <= 1'b0;
          tgt_r <= 10'h000;
          tmr_r <= 10'h000;
          loop_r <= 6'h00;
          loop_act_r <= 1'b0;
          wmask_r <= 4'h0;
          send_r <= 4'h0;
          irq_r <= 1'b0;
        end
        else
        begin
          send_r <= 4'h0;
          irq_r <= 1'b0;
          if (mode == `LESQ_MODE_CLRPC)
          begin
            // Software rewind: counter to zero, engine held.
            pc_r <= 5'h00;
            loop_act_r <= 1'b0;
            st_r <= S_FETCH;
          end
          else if (!run)
          begin
            // Ended engines may restart once software leaves run mode.
            if (st_r == S_ENDED || st_r == S_EXEC)
            begin
              st_r <= S_FETCH;
            end
          end
          else
          begin
            case (st_r)
              S_FETCH:
              begin
                st_r <= S_EXEC;
              end
              S_EXEC:
              begin
                st_r <= S_FETCH;
                pc_r <= pc_r + 5'h01;
                tmr_r <= 10'h000;
                case (ins[`LESQ_OP])
                  `LESQ_OP_RAMP:
                  begin
                    // Step field holds count minus one: 1..128 steps.
                    neg_r <= ins[`LESQ_RAMP_NEG];
                    steps_r <= {1'b0, ins[`LESQ_RAMP_STEPS]} + 8'h01;
                    tgt_r <= ins[`LESQ_TIME];
                    pc_r <= pc_r;
                    st_r <= S_RAMP;
                  end
                  `LESQ_OP_WAIT:
                  begin
                    tgt_r <= ins[`LESQ_TIME];
                    pc_r <= pc_r;
                    st_r <= S_WAIT;
                  end
                  `LESQ_OP_BRANCH:
                  begin
                    if (ins[`LESQ_BR_CNT] == 6'h00)
                    begin
                      pc_r <= ins[`LESQ_BR_TGT];
                    end
                    else if (!loop_act_r)
                    begin
                      loop_act_r <= 1'b1;
                      loop_r <= ins[`LESQ_BR_CNT] - 6'h01;
                      pc_r <= ins[`LESQ_BR_TGT];
                    end
                    else if (loop_r != 6'h00)
                    begin
                      loop_r <= loop_r - 6'h01;
                      pc_r <= ins[`LESQ_BR_TGT];
                    end
                    else
                    begin
                      // Loop exhausted: fall through and rearm.
                      loop_act_r <= 1'b0;
                    end
                  end
                  `LESQ_OP_SET:
                  begin
                    duty_r <= ins[`LESQ_SET_VAL];
                  end
                  `LESQ_OP_START:
                  begin
                    pc_r <= 5'h00;
                    loop_act_r <= 1'b0;
                  end
                  `LESQ_OP_TRIG:
                  begin
                    // Sends leave at once; a wait holds the counter.
                    send_r <= ins[`LESQ_TRG_SEND];
                    wmask_r <= ins[`LESQ_TRG_WAIT];
                    if (ins[`LESQ_TRG_WAIT] != 4'h0)
                    begin
                      pc_r <= pc_r;
                      st_r <= S_TRIG;
                    end
                  end
                  `LESQ_OP_END:
                  begin
                    irq_r <= ins[`LESQ_END_IRQ];
                    pc_r <= ins[`LESQ_END_RPC] ? 5'h00 : pc_r;
                    st_r <= S_ENDED;
                  end
                  default:
                  begin
                    // Undefined opcodes are skipped.
                    st_r <= S_FETCH;
                  end
                endcase
              end
              S_RAMP:
              begin
                if (ms_tick_r)
                begin
                  tmr_r <= tick_done ? 10'h000 : tmr_r + 10'h001;
                end
                if (tick_done)
                begin
                  // Saturate at the ends of the duty range.
                  if (neg_r && duty_r != 8'h00)
                  begin
                    duty_r <= duty_r - 8'h01;
                  end
                  else if (!neg_r && duty_r != 8'hff)
                  begin
                    duty_r <= duty_r + 8'h01;
                  end
                  steps_r <= steps_r - 8'h01;
                  if (steps_r == 8'h01)
                  begin
                    pc_r <= pc_r + 5'h01;
                    st_r <= S_FETCH;
                  end
                end
              end
              S_WAIT:
              begin
                if (ms_tick_r)
                begin
                  tmr_r <= tmr_r + 10'h001;
                end
                if (tick_done)
                begin
                  pc_r <= pc_r + 5'h01;
                  st_r <= S_FETCH;
                end
              end
              S_TRIG:
              begin
                if ((seen_r & wmask_r) == wmask_r)
                begin
                  pc_r <= pc_r + 5'h01;
                  st_r <= S_FETCH;
                end
              end
              S_ENDED:
              begin
                // Stopped until software takes the engine out of run.
                st_r <= S_ENDED;
              end
              default:
              begin
                st_r <= S_FETCH;
              end
            endcase
          end
        end
      end
    end
  endgenerate
endmodule

/* inc/lesq_defs.vh */
// Constants shared by the LED engine sequencer design files.
`ifndef LESQ_DEFS_VH
`define LESQ_DEFS_VH
// Timing: one millisecond expressed in nanoseconds, and the clock period.
`define LESQ_MS_NS 1000000
`define LESQ_CLK_NS 10
// Register byte offsets on the bus.
`define LESQ_ADR_CTRL 10'h000
`define LESQ_ADR_STAT 10'h004
`define LESQ_ADR_MASK 10'h008
`define LESQ_ADR_DUTY 10'h00c
`define LESQ_ADR_PC 10'h010
`define LESQ_ADR_MEM0 10'h100
`define LESQ_ADR_MEM3 10'h280
// Control register: engine i mode sits at [MODE_HI-2i -: 2], red at [5:4].
`define LESQ_MODE_HI 5
`define LESQ_CTRL_RST 8'h00
`define LESQ_MODE_HOLD 2'h0
`define LESQ_MODE_RUN 2'h2
`define LESQ_MODE_CLRPC 2'h3
// Program memory geometry per engine section.
`define LESQ_AW 5
`define LESQ_DW 24
`define LESQ_DEPTH 32
// Instruction fields.
`define LESQ_OP 23:21
`define LESQ_RAMP_NEG 20
`define LESQ_RAMP_STEPS 19:13
`define LESQ_TIME 9:0
`define LESQ_BR_CNT 13:8
`define LESQ_BR_TGT 4:0
`define LESQ_SET_VAL 7:0
`define LESQ_TRG_WAIT 7:4
`define LESQ_TRG_SEND 3:0
`define LESQ_END_IRQ 1
`define LESQ_END_RPC 0
// Opcodes.
`define LESQ_OP_RAMP 3'h0
`define LESQ_OP_WAIT 3'h1
`define LESQ_OP_BRANCH 3'h2
`define LESQ_OP_SET 3'h3
`define LESQ_OP_START 3'h4
`define LESQ_OP_TRIG 3'h5
`define LESQ_OP_END 3'h6
`endif

/* hdl/lesq_pmem.v */
// Program memory for one engine section, write port and registered read.
`timescale 1ns/100ps
`include "lesq_defs.vh"
module lesq_pmem
(
  input wire clk_i,
  input wire we_i,
  input wire [`LESQ_AW-1:0] waddr_i,
  input wire [`LESQ_DW-1:0] wdata_i,
  input wire [`LESQ_AW-1:0] raddr_i,
  output reg [`LESQ_DW-1:0] rdata_o
);
  // Storage array; contents are undefined until software loads a program.
  reg [`LESQ_DW-1:0] mem_r [0:`LESQ_DEPTH-1];

  // Write and read each clock; read data are registered.
  always @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule

/* hdl/lesq_pwm.v */
// Free running eight-bit PWM generator for one LED channel.
`timescale 1ns/100ps
`include "lesq_defs.vh"
module lesq_pwm
(
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] duty_i,
  output reg pwm_o
);
  // Period counter; duty 0 stays low, 255 is high 255 of 256 slots.
  reg [7:0] cnt_r;

  // Compare the counter against the duty each cycle.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 8'h00;
      pwm_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
      pwm_o <= (cnt_r < duty_i);
    end
  end
endmodule

/* bench/lesq_top_chk.sv */
// Port checker for the LED engine sequencer, bound to the top module.
`timescale 1ns/100ps
module lesq_top_chk
#(
  parameter MS_CYCLES = 10
)
(
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [9:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire ext_trig_i,
  input wire ext_trig_o,
  input wire [2:0] pwm_o,
  input wire irq_o
);
  reg [7:0] ctrl_r; // Control value as last written over the bus.
  reg [2:0] mask_r; // Mask value as last written over the bus.
  reg [2:0] idle_r; // Cycles since any engine was last in run mode.
  wire wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire run_any = (ctrl_r[5:4] == 2'h2) || (ctrl_r[3:2] == 2'h2) || (ctrl_r[1:0] == 2'h2);
  // Shadows follow acknowledged writes only, so a refused lane never moves them.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= 8'h00;
      mask_r <= 3'h0;
      idle_r <= 3'h0;
    end
    else
    begin
      if (wr_ok && wb_adr_i[9:2] == 8'h00)
        ctrl_r <= wb_dat_i[7:0];
      if (wr_ok && wb_adr_i[9:2] == 8'h02)
        mask_r <= wb_dat_i[2:0];
      if (run_any)
        idle_r <= 3'h0;
      else if (idle_r != 3'h7)
        idle_r <= idle_r + 3'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_CTRL_READ: assert property (rd_ack && wb_adr_i[9:2] == 8'h00 |-> wb_dat_o[7:0] == ctrl_r)
    else $error("control read differs from written value");
  AST_MEM_READ: assert property (rd_ack && wb_adr_i[9:8] != 2'h0 |-> wb_dat_o == 32'h0)
    else $error("program window read not zero");
  AST_IRQ_MASK: assert property (irq_o |-> mask_r != 3'h0)
    else $error("interrupt with all sources masked");
  AST_MASK_OFF: assert property (wr_ok && wb_adr_i[9:2] == 8'h02 && wb_dat_i[2:0] == 3'h0
    |=> !irq_o [*2])
    else $error("interrupt after mask cleared");
  AST_EXT_PULSE: assert property (ext_trig_o |=> !ext_trig_o)
    else $error("trigger out longer than one cycle");
  AST_HOLD_QUIET: assert property (idle_r >= 3'h4 |-> !ext_trig_o)
    else $error("trigger sent with no engine running");
  AST_RESET_OUT: assert property ($past(rst_i) |-> !wb_ack_o && !ext_trig_o && !irq_o && pwm_o == 3'h0)
    else $error("outputs not quiet after reset");
  cover property (ext_trig_o);
  cover property ($rose(irq_o));
  cover property (rd_ack && wb_adr_i[9:2] == 8'h00);
endmodule
bind lesq_top lesq_top_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ext_trig_i(ext_trig_i), .ext_trig_o(ext_trig_o), .pwm_o(pwm_o), .irq_o(irq_o));

/* bench/lesq_host.sv */
// Host controller model: a classic Wishbone master that loads programs.
`timescale 1ns/100ps
module lesq_host
(
  input wire clk_i,
  input wire ack_i,
  input wire [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // Idle bus at time zero.
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // One access; the request stands until ack is sampled, then is dropped.
  task automatic xfer(input bit w, input [9:0] a, input [31:0] d, input [3:0] s,
    output [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a live one.
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule

/* bench/test_lesq_top.sv */
// Self-checking testbench for the LED engine sequencer.
`timescale 1ns/100ps
module test_lesq_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ext_trig_i = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ext_trig_o, irq_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0] pwm_o;
  logic [7:0] v;
  int fails = 0;
  int comparisons = 0;
  int seed = 31;
  int cycles = 0;
  int rv;
  int hi; // High slots of the red PWM over one full period.
  int exp_duty[3]; // Model of the duties the programs must leave.
  int prog[$]; // Program words of the section being loaded.
  bit seen;
  always #5 clk_i = ~clk_i;
  lesq_top #(.MS_CYCLES(10)) u_lesq_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_trig_i(ext_trig_i),
    .ext_trig_o(ext_trig_o), .pwm_o(pwm_o), .irq_o(irq_o));
  lesq_host u_host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  // Compare one value and count it.
  task automatic chk(input string nm, input [31:0] seen_v, input [31:0] exp_v);
    comparisons++;
    if (seen_v !== exp_v)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask
  task automatic wr(input [9:0] a, input [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd_chk(input string nm, input [9:0] a, input [31:0] m, input [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, q & m, e);
  endtask
  task automatic load(input int base);
    foreach (prog[i])
      wr(10'(base + 4 * i), prog[i]);
  endtask
  task report_and_stop;
    if (fails == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A hang is cut short well past the expected run length.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("control", 10'h000, 32'hffffffff, 0);
    rd_chk("status", 10'h004, 32'hffffffff, 0);
    rd_chk("unmapped", 10'h050, 32'hffffffff, 0);
    rd_chk("program window", 10'h104, 32'hffffffff, 0);
    // Hold-only modes keep the engines still while the mode field is probed.
    v = 8'($random(seed)) & 8'hd5;
    wr(10'h000, {24'h0, v});
    rd_chk("control", 10'h000, 32'hff, {24'h0, v});
    u_host.xfer(1'b1, 10'h000, 32'hff, 4'he, q);
    rd_chk("control", 10'h000, 32'hff, {24'h0, v});
    rv = ($random(seed) & 32'h7f) + 16;
    exp_duty[0] = rv + 2;
    exp_duty[1] = 2 * (3 + 1);
    // Every branch target sits before its branch.
    prog = '{32'h600000 | rv, 32'ha0008a, 32'h002001, 32'h200002, 32'hc00003};
    load(256);
    prog = '{32'ha00010, 32'h600000, 32'h002001, 32'h400302, 32'hc00002};
    load(384);
    prog = '{32'h600040, 32'h102001, 32'h400000};
    load(512);
    wr(10'h008, 32'h3);
    wr(10'h000, 32'h2a);
    // Red sends to green and to the external line as soon as it reaches its trigger.
    seen = 1'b0;
    repeat (60)
    begin
      @(posedge clk_i);
      if (ext_trig_o === 1'b1)
        seen = 1'b1;
    end
    chk("trigger out", seen, 1);
    rd_chk("red duty", 10'h00c, 32'hff, rv);
    rd_chk("red pc", 10'h010, 32'h1f, 1);
    // Green was released by that send, so it has left its first word for good.
    u_host.xfer(1'b0, 10'h010, 32'h0, 4'hf, q);
    chk("green pc moved", q[12:8] != 5'h00, 1);
    ext_trig_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ext_trig_i <= 1'b0;
    // No program word sends to the external line a second time.
    seen = 1'b0;
    repeat (100)
    begin
      @(posedge clk_i);
      if (ext_trig_o === 1'b1)
        seen = 1'b1;
    end
    chk("trigger quiet", seen, 0);
    repeat (300) @(posedge clk_i);
    u_host.xfer(1'b0, 10'h00c, 32'h0, 4'hf, q);
    chk("red duty", q[7:0], exp_duty[0]);
    chk("green duty", q[15:8], exp_duty[1]);
    chk("blue band", q[23:16] >= 8'h3e && q[23:16] <= 8'h40, 1);
    // The ended red engine holds its duty, so one period shows it exactly.
    hi = 0;
    repeat (256)
    begin
      @(posedge clk_i);
      hi = hi + pwm_o[0];
    end
    chk("red pwm", hi, exp_duty[0]);
    u_host.xfer(1'b0, 10'h010, 32'h0, 4'hf, q);
    chk("red pc", q[4:0], 0);
    chk("blue pc band", q[20:16] <= 5'h2, 1);
    rd_chk("status", 10'h004, 32'h7, 3);
    chk("irq", irq_o, 1);
    wr(10'h008, 32'h0);
    @(negedge clk_i);
    chk("irq masked", irq_o, 0);
    wr(10'h008, 32'h3);
    wr(10'h004, 32'h3);
    rd_chk("status", 10'h004, 32'h7, 0);
    chk("irq cleared", irq_o, 0);
    // Green mode three rewinds its counter while the engine is held.
    wr(10'h000, 32'h0c);
    rd_chk("green pc", 10'h010, 32'h1f00, 0);
    report_and_stop();
  end
endmodule
